// ### pwm_chk_checker.sv
// Port checker for pwm_top.
// Assumes flags of registers 4 to 7 sit in bit 15.
`timescale 1ns/1ps
`default_nettype none
module pwm_chk(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic soft_reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic pwm_output_pin,
	input wire logic pwm_output_pin_oe_b,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	logic [3:0] m;
	wire o=pwm_output_pin,pw=m[0]&m[1],hi=pw|m[3],lo=pw|!m[3],q=m[reg_addr[1:0]];
	// Soft reset clears these flags just as hard reset does, whatever the clock enable.
	always @(posedge clk) begin
		if(!rst_b|soft_reset) m<=4'h0;
		else if(clk_en&reg_wr&reg_addr[2]) m[reg_addr[1:0]]<=reg_wdata[15];
	end
	default clocking @(posedge clk); endclocking
	default disable iff(!rst_b);
	pin_rst_a: assert property(!$past(rst_b)|->!o&pwm_output_pin_oe_b) else $error("reset");
	rd_hold_a: assert property(!(clk_en&reg_rd)|=>$stable(reg_rdata)) else $error("rdata");
	pin_freeze_a: assert property(!clk_en|=>$stable(o)) else $error("freeze");
	dir_oe_a: assert property($past(clk_en)&$stable(m)|->pwm_output_pin_oe_b==!m[2]) else $error("oe");
	port_pin_a: assert property($past(clk_en)&!pw&$stable(m)|->o==m[3]) else $error("port");
	flag_rd_a: assert property(clk_en&reg_rd&reg_addr[2]|=>reg_rdata[15]==$past(q)) else $error("flag");
	pin_rise_a: assert property($rose(o)|->$past(hi)) else $error("rise");
	pin_fall_a: assert property($fell(o)&$past(rst_b)|->$past(lo)) else $error("fall");
	soft_oe_a: assert property(soft_reset##1clk_en|=>pwm_output_pin_oe_b) else $error("soft oe");
	cover property(pw&$rose(o));
	cover property(!clk_en&reg_wr);
	cover property(!pw&o);
endmodule
bind pwm_top pwm_chk u_chk(.clk,.rst_b,.clk_en,.soft_reset,.reg_wr,.reg_rd,.pwm_output_pin,.pwm_output_pin_oe_b,.reg_addr,
	.reg_wdata,.reg_rdata);
`default_nettype wire

// ### pwm_counter.v
// Free-running up-counter that wraps at a programmable top value.
// Assumes clk at the counting rate and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defs.vh"
module pwm_counter #(
	parameter W = `CNT_W
) (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire [W-1:0] top,
	output reg [W-1:0] count,
	output wire at_top
);
	assign at_top = (count >= top);
	always @(posedge clk) begin
		if (!rst_b) begin
			count <= {W{1'b0}};
		end else if (clk_en) begin
			// A top lowered below the count wraps at once instead of running through 2^16.
			if (at_top) begin
				count <= {W{1'b0}};
			end else begin
				count <= count + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

// ### pwm_defs.vh
// Constants for the top/compare PWM generator: register indices, field positions, reset values.
// Assumes inclusion by bare name from the PWM design files.
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH
`define REG_ADDR_W 3
`define REG_TOP_VALUE 3'h0
`define REG_TOP_INITIAL 3'h1
`define REG_CMP_VALUE 3'h2
`define REG_CMP_INITIAL 3'h3
`define REG_FUNC_CONFIG 3'h4
`define REG_PIN_FUNCTION 3'h5
`define REG_PORT_DIR 3'h6
`define REG_OUT_BUF 3'h7
`define CNT_W 16
`define TOP_INITIAL_DEFAULT 16'h3a98
`define CMP_INITIAL_DEFAULT 16'h1d4c
`define ZERO16 16'h0000
`define ONE16 16'h0001
`define PWM_ENABLE_BIT 15
`define PIN_FUNC_BIT 15
`define PORT_DIR_BIT 15
`define OUT_BUF_BIT 15
`endif

// ### pwm_top.v
// Contract
// - A 16-bit counter counts from zero up to top at the clock rate, then restarts.
// - Reaching top with the PWM function enabled sets the PWM output high.
// - Reaching the compare value clears the PWM output low.
// - PWM drives the special-function pin only while the enable bit is set.
// - Period is top plus one clock ticks.
// - High time is compare ticks out of top plus one.
// - Working top loads from its initial copy after reset.
// - Working compare loads from its initial copy after reset.
// - Initial top defaults to 3A98 hex.
// - Initial compare defaults to 1D4C hex.
// - Initial copies act after the next reset; working values act immediately.
// - The pin shows the level only when configured as an output.
//
// Single-channel PWM generator with its register file on a simple local port.
// Assumes one 12 MHz domain; the initial copies model non-volatile storage and survive soft reset.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defs.vh"
module pwm_top #(
	parameter W = `CNT_W
) (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire soft_reset,
	input wire reg_wr,
	input wire reg_rd,
	input wire [`REG_ADDR_W-1:0] reg_addr,
	input wire [W-1:0] reg_wdata,
	output reg [W-1:0] reg_rdata,
	output reg pwm_output_pin,
	output reg pwm_output_pin_oe_b
);
	reg [W-1:0] pwm_top_value;
	reg [W-1:0] pwm_top_initial;
	reg [W-1:0] pwm_compare_value;
	reg [W-1:0] pwm_compare_initial;
	reg [W-1:0] function_config_reg;
	reg [W-1:0] pin_function_reg;
	reg [W-1:0] port_direction_reg;
	reg [W-1:0] out_buf_reg;
	reg nv_valid;
	reg pwm_level;
	reg next_pwm_level;
	reg [W-1:0] next_rdata;
	wire [W-1:0] count;
	wire at_top;
	wire pwm_en;
	wire reload;
	wire pwm_on_pin;
	wire wr_strobe;
	reg [W-1:0] next_count;

	assign pwm_en = function_config_reg[`PWM_ENABLE_BIT];
	assign reload = !rst_b || soft_reset;
	assign pwm_on_pin = pwm_en && pin_function_reg[`PIN_FUNC_BIT];
	assign wr_strobe = clk_en && reg_wr;

	pwm_counter #(.W(W)) u_counter (
		.clk(clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.top(pwm_top_value),
		.count(count),
		.at_top(at_top)
	);

	function wr_hit;
		input [`REG_ADDR_W-1:0] a;
		input [`REG_ADDR_W-1:0] r;
		begin
			wr_hit = (a == r);
		end
	endfunction

	// Next value of the free-running count, mirrored from the counter so the clear can look one tick ahead.
	function [W-1:0] step_count;
		input [W-1:0] c;
		input wrap;
		begin
			if (wrap) begin
				step_count = {W{1'b0}};
			end else begin
				step_count = c + {{(W-1){1'b0}}, 1'b1};
			end
		end
	endfunction

	// The initial copies are not cleared by reset, so they behave like non-volatile storage.
	always @(posedge clk) begin
		if (!nv_valid) begin
			pwm_top_initial <= `TOP_INITIAL_DEFAULT;
			pwm_compare_initial <= `CMP_INITIAL_DEFAULT;
			nv_valid <= 1'b1;
		end else if (wr_strobe && rst_b) begin
			if (wr_hit(reg_addr, `REG_TOP_INITIAL)) begin
				pwm_top_initial <= reg_wdata;
			end
			if (wr_hit(reg_addr, `REG_CMP_INITIAL)) begin
				pwm_compare_initial <= reg_wdata;
			end
		end
	end

	initial nv_valid = 1'b0;

	// Working values reload on either reset; a write lands at once so a period change needs no restart.
	always @(posedge clk) begin
		if (reload) begin
			pwm_top_value <= nv_valid ? pwm_top_initial : `TOP_INITIAL_DEFAULT;
			pwm_compare_value <= nv_valid ? pwm_compare_initial : `CMP_INITIAL_DEFAULT;
		end else if (wr_strobe) begin
			case (reg_addr)
				`REG_TOP_VALUE: begin
					pwm_top_value <= reg_wdata;
				end
				`REG_CMP_VALUE: begin
					pwm_compare_value <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always @(posedge clk) begin
		if (reload) begin
			function_config_reg <= `ZERO16;
			pin_function_reg <= `ZERO16;
			port_direction_reg <= `ZERO16;
			out_buf_reg <= `ZERO16;
		end else if (wr_strobe) begin
			case (reg_addr)
				`REG_FUNC_CONFIG: begin
					function_config_reg <= reg_wdata;
				end
				`REG_PIN_FUNCTION: begin
					pin_function_reg <= reg_wdata;
				end
				`REG_PORT_DIR: begin
					port_direction_reg <= reg_wdata;
				end
				`REG_OUT_BUF: begin
					out_buf_reg <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// The pin is registered, so the clear is decoded one count early: the high time is exactly compare ticks.
	// Clear wins over set, so a compare of zero gives a constant low output.
	always @* begin
		next_count = step_count(count, at_top);
		next_pwm_level = pwm_level;
		if (at_top && pwm_en) begin
			next_pwm_level = 1'b1;
		end
		if (next_count == pwm_compare_value) begin
			next_pwm_level = 1'b0;
		end
	end

	always @* begin
		case (reg_addr)
			`REG_TOP_VALUE: begin
				next_rdata = pwm_top_value;
			end
			`REG_TOP_INITIAL: begin
				next_rdata = pwm_top_initial;
			end
			`REG_CMP_VALUE: begin
				next_rdata = pwm_compare_value;
			end
			`REG_CMP_INITIAL: begin
				next_rdata = pwm_compare_initial;
			end
			`REG_FUNC_CONFIG: begin
				next_rdata = function_config_reg;
			end
			`REG_PIN_FUNCTION: begin
				next_rdata = pin_function_reg;
			end
			`REG_PORT_DIR: begin
				next_rdata = port_direction_reg;
			end
			`REG_OUT_BUF: begin
				next_rdata = out_buf_reg;
			end
			default: begin
				next_rdata = `ZERO16;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_b) begin
			pwm_level <= 1'b0;
			reg_rdata <= `ZERO16;
		end else if (clk_en) begin
			pwm_level <= next_pwm_level;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// The pin and its enable come straight from flops, so the pad never sees a decode glitch.
	always @(posedge clk) begin
		if (!rst_b) begin
			pwm_output_pin <= 1'b0;
			pwm_output_pin_oe_b <= 1'b1;
		end else if (clk_en) begin
			if (pwm_on_pin) begin
				pwm_output_pin <= next_pwm_level;
			end else begin
				pwm_output_pin <= out_buf_reg[`OUT_BUF_BIT];
			end
			pwm_output_pin_oe_b <= !port_direction_reg[`PORT_DIR_BIT];
		end
	end
endmodule
`default_nettype wire

// ### pwm_top_tb.sv
// Bench for pwm_top: random periods, resets and gating.
// Assumes the register indices of pwm_defs.vh.
`timescale 1ns/1ps
`default_nettype none
module pwm_top_tb;
	logic clk=0,rst_b=0,clk_en=1,soft_reset=0,reg_wr=0,reg_rd=0,pin,oe_b;
	logic [2:0] reg_addr=0;
	logic [15:0] reg_wdata=0,reg_rdata,t,h,p;
	logic [31:0] s=32'h02f9_3608;
	int err_total=0,check_count=0;
	pwm_top u_dut(.clk,.rst_b,.clk_en,.soft_reset,.reg_wr,.reg_rd,.reg_addr,.reg_wdata,.reg_rdata,
		.pwm_output_pin(pin),.pwm_output_pin_oe_b(oe_b));
	initial forever #25 clk=~clk;
	function logic [31:0] nx(input logic [31:0] x);
		x^=x<<13;
		x^=x>>17;
		return x^x<<5;
	endfunction
	task close_out(input int bad);
		err_total+=bad;
		$display("checks %0d errors %0d",check_count,err_total);
		if(err_total==0&&check_count>0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [15:0] g,x);
		check_count++;
		if(g!==x) begin
			err_total++;
			$display("unexpected %0t %h %h",$time,g,x);
		end
	endtask
	task op(input logic w,input logic [2:0] a,input logic [15:0] d);
		@(negedge clk) {reg_wr,reg_rd,reg_addr,reg_wdata}={w,!w,a,d};
		@(negedge clk) {reg_wr,reg_rd}=2'h0;
		if(!w) chk(reg_rdata,d);
	endtask
	task hold(input logic v,output logic [15:0] n);
		for(n=0;pin!==v;n++) begin
			@(negedge clk);
			if(n>999) close_out(1);
		end
	endtask
	task run(input logic [15:0] tt,cc);
		op(1,0,tt);
		op(1,2,cc);
		op(0,0,tt);
		hold(0,h);
		hold(1,h);
		hold(0,h);
		chk(h,cc);
		hold(1,p);
		chk(h+p,tt+16'h0001);
		$display("period %0d done",tt);
	endtask
	initial begin
		repeat(2) @(negedge clk);
		rst_b=1;
		op(0,0,16'h3a98);
		op(0,2,16'h1d4c);
		op(0,1,16'h3a98);
		op(0,3,16'h1d4c);
		$display("reset values done");
		op(1,6,16'h8000);
		op(1,5,16'h8000);
		op(1,4,16'h8000);
		chk({15'h0000,oe_b},16'h0000);
		repeat(4) begin
			s=nx(s);
			t=16'h0004+s[4:0];
			run(t,16'h0001+s[15:8]%(t-16'h0001));
		end
		op(1,1,16'h0010);
		op(1,3,16'h0005);
		op(0,0,t);
		op(0,1,16'h0010);
		@(negedge clk) soft_reset=1;
		@(negedge clk) soft_reset=0;
		op(0,0,16'h0010);
		op(0,2,16'h0005);
		$display("soft reset done");
		clk_en=0;
		op(1,0,16'h0020);
		clk_en=1;
		op(0,0,16'h0010);
		$display("gating done");
		op(1,4,16'h0000);
		op(1,7,16'h8000);
		op(1,6,16'h0000);
		chk({15'h0000,pin},16'h0001);
		@(negedge clk);
		chk({15'h0000,oe_b},16'h0001);
		$display("port done");
		rst_b=0;
		repeat(2) @(negedge clk);
		rst_b=1;
		op(0,0,16'h0010);
		op(0,2,16'h0005);
		$display("hard reset done");
		close_out(0);
	end
endmodule
`default_nettype wire
